// ===== common/prc_defines.svh
`ifndef PRC_DEFINES_SVH
`define PRC_DEFINES_SVH

// register byte offsets
`define PRC_OFF_PLL_CFG  12'h000
`define PRC_OFF_STATUS   12'h004
`define PRC_OFF_OSC_MHZ  12'h008
`define PRC_OFF_PORT_SEL 12'h00c
`define PRC_OFF_CLKBLK0  12'h010
`define PRC_OFF_CLKBLK1  12'h014
`define PRC_OFF_TIMER0   12'h018
`define PRC_OFF_TIMER1   12'h01c

// pll configuration field positions
`define PRC_F_LSB   0
`define PRC_F_MSB   11
`define PRC_R_LSB   12
`define PRC_R_MSB   17
`define PRC_OD_LSB  20
`define PRC_OD_MSB  22

// clock block field positions
`define PRC_CB_SRC_EXT 0
`define PRC_CB_PIN_EN  1
`define PRC_CB_DIV_LSB 8
`define PRC_CB_DIV_MSB 15

// strap defaults: multiplier, reference divider, output divider
`define PRC_F_00  12'h07a
`define PRC_F_11  12'h077
`define PRC_F_10  12'h031
`define PRC_F_01  12'h017
`define PRC_R_DEF 6'h00
`define PRC_OD_00 3'h1
`define PRC_OD_XX 3'h2

// reset values
`define PRC_OSC_RST      8'h19
`define PRC_PORT_SEL_RST 4'h0
`define PRC_CB_RST       16'h0000

// timing
`define PRC_CLK_MHZ      200
`define PRC_REF_MHZ      100
`define PRC_STRAP_EDGE   2'h2
`define PRC_SETTLE_NS    500
`define PRC_SETTLE_CYC   ((`PRC_SETTLE_NS * `PRC_CLK_MHZ + 999) / 1000)
`define PRC_BOOT_US      15
`define PRC_BOOT_CYC     (`PRC_BOOT_US * `PRC_CLK_MHZ)
`define PRC_IF_MIN_MHZ   260
`define PRC_IF_MAX_MHZ   1300

`endif

// ===== common/prc_pkg.sv
package prc_pkg;

  // pll control states, one-hot
  typedef enum logic [2:0] {
    PRC_ST_STRAP  = 3'b001,
    PRC_ST_SETTLE = 3'b010,
    PRC_ST_RUN    = 3'b100
  } prc_state_t;

endpackage

// ===== design/prc_ratio_ce.sv
`timescale 1ns/1ps
`default_nettype none

// fractional enable generator: pulse rate = inc / modulus per clock
module prc_ratio_ce (
  input  wire logic        pclk,     // system clock
  input  wire logic        presetn,  // async reset, active low
  input  wire logic        enable,   // run gate
  input  wire logic [23:0] inc,      // step per clock
  input  wire logic [23:0] modulus,  // wrap value
  output logic             tick      // one-cycle enable
);

  logic [24:0] acc;
  logic [24:0] next_acc;
  logic        next_tick;
  logic [24:0] sum;

  // accumulate and wrap; a step at or above the modulus pulses every cycle
  always_comb begin
    sum       = acc + {1'b0, inc};
    next_acc  = acc;
    next_tick = 1'b0;
    if (!enable) begin
      next_acc = '0;
    end else if (inc >= modulus) begin
      next_acc  = '0;
      next_tick = 1'b1;
    end else if (sum >= {1'b0, modulus}) begin
      next_acc  = sum - {1'b0, modulus};
      next_tick = 1'b1;
    end else begin
      next_acc = sum;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc  <= '0;
      tick <= 1'b0;
    end else begin
      acc  <= next_acc;
      tick <= next_tick;
    end
  end

endmodule

`default_nettype wire

// ===== design/prc_clock_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "prc_defines.svh"

module prc_clock_control
  import prc_pkg::*;
(
  input  wire logic        pclk,                // 200 MHz system clock
  input  wire logic        presetn,             // async reset, active low
  input  wire logic        psel,                // apb select
  input  wire logic        penable,             // apb access phase
  input  wire logic        pwrite,              // apb direction
  input  wire logic [11:0] paddr,               // apb byte address
  input  wire logic [31:0] pwdata,              // apb write data
  output logic      [31:0] prdata,              // apb read data
  output logic             pready,              // apb ready
  output logic             pslverr,             // apb error
  input  wire logic        ratio_select_bit_low,  // strap pin
  input  wire logic        ratio_select_bit_high, // strap pin
  input  wire logic [1:0]  ext_clk_pin,         // external clock inputs
  output logic             pll_tick,            // pll rate enable
  output logic             switch_tick,         // switch clock enable
  output logic             tile_tick,           // tile clock enable
  output logic             ref_tick,            // reference clock enable
  output logic [3:0]       port_clk_tick,       // per-port clock enable
  output logic [1:0]       clkblk_pin_out,      // clock block pin level
  output logic [1:0]       clkblk_pin_oe,       // clock block pin enable
  output logic             pll_locked,          // clocks running
  output logic             boot_done            // boot may start
);
  // strap decode to {od, r, f}
  function automatic logic [20:0] strap_cfg(input logic [1:0] s);
    case (s)
      2'b00:   strap_cfg = {`PRC_OD_00, `PRC_R_DEF, `PRC_F_00};
      2'b11:   strap_cfg = {`PRC_OD_XX, `PRC_R_DEF, `PRC_F_11};
      2'b10:   strap_cfg = {`PRC_OD_XX, `PRC_R_DEF, `PRC_F_10};
      default: strap_cfg = {`PRC_OD_XX, `PRC_R_DEF, `PRC_F_01};
    endcase
  endfunction
  prc_state_t  state, next_state;
  logic [1:0]  edge_cnt, next_edge_cnt;
  logic [11:0] wait_cnt, next_wait_cnt;
  logic [11:0] boot_cnt, next_boot_cnt;
  logic        next_boot_done;
  logic [1:0]  strap, next_strap;
  logic [11:0] mul_f, next_mul_f;
  logic [5:0]  ref_r, next_ref_r;
  logic [2:0]  output_divider, next_output_divider;
  logic [7:0]  osc_mhz, next_osc_mhz;
  logic [3:0]  port_sel, next_port_sel;
  logic [15:0] cb_cfg [2];
  logic [15:0] next_cb_cfg [2];
  logic [31:0] timer [2];
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        wr_en, rd_setup, cfg_wr, range_err;
  logic [23:0] step, if_mod, tile_mod, lo_lim, hi_lim;
  logic [1:0]  cb_tick;

  assign pready   = 1'b1; // zero wait states
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign cfg_wr   = wr_en & (paddr == `PRC_OFF_PLL_CFG);
  assign pll_locked = (state == PRC_ST_RUN);

  // strap capture, settle and boot sequencing
  always_comb begin
    next_state    = state;
    next_edge_cnt = edge_cnt;
    next_wait_cnt = wait_cnt;
    next_boot_cnt = boot_cnt;
    next_boot_done = boot_done;
    next_strap    = strap;
    case (state)
      PRC_ST_STRAP: begin
        next_edge_cnt = edge_cnt + 2'h1;
        if (edge_cnt == `PRC_STRAP_EDGE) begin
          next_strap    = {ratio_select_bit_high, ratio_select_bit_low};
          next_state    = PRC_ST_SETTLE;
          next_wait_cnt = '0;
        end
      end
      PRC_ST_SETTLE: begin
        next_wait_cnt = wait_cnt + 12'h1;
        if (wait_cnt == 12'(`PRC_SETTLE_CYC - 1)) begin
          next_state = PRC_ST_RUN;
        end
      end
      PRC_ST_RUN: begin
        if (!boot_done) begin
          next_boot_cnt = boot_cnt + 12'h1;
          if (boot_cnt == 12'(`PRC_BOOT_CYC - 1)) begin
            next_boot_done = 1'b1;
          end
        end
      end
      default: next_state = PRC_ST_STRAP;
    endcase
    if (cfg_wr && state != PRC_ST_STRAP) begin
      next_state    = PRC_ST_SETTLE;
      next_wait_cnt = '0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= PRC_ST_STRAP;
      edge_cnt  <= '0;
      wait_cnt  <= '0;
      boot_cnt  <= '0;
      boot_done <= 1'b0;
      strap     <= '0;
    end else begin
      state     <= next_state;
      edge_cnt  <= next_edge_cnt;
      wait_cnt  <= next_wait_cnt;
      boot_cnt  <= next_boot_cnt;
      boot_done <= next_boot_done;
      strap     <= next_strap;
    end
  end
  // software registers; strap defaults load at capture
  always_comb begin
    next_mul_f          = mul_f;
    next_ref_r          = ref_r;
    next_output_divider = output_divider;
    next_osc_mhz        = osc_mhz;
    next_port_sel       = port_sel;
    next_cb_cfg         = cb_cfg;
    if (state == PRC_ST_STRAP && edge_cnt == `PRC_STRAP_EDGE) begin
      {next_output_divider, next_ref_r, next_mul_f} =
        strap_cfg({ratio_select_bit_high, ratio_select_bit_low});
    end
    if (cfg_wr) begin
      next_mul_f          = pwdata[`PRC_F_MSB:`PRC_F_LSB];
      next_ref_r          = pwdata[`PRC_R_MSB:`PRC_R_LSB];
      next_output_divider = pwdata[`PRC_OD_MSB:`PRC_OD_LSB];
    end
    if (wr_en) begin
      case (paddr)
        `PRC_OFF_OSC_MHZ:  next_osc_mhz   = pwdata[7:0];
        `PRC_OFF_PORT_SEL: next_port_sel  = pwdata[3:0];
        `PRC_OFF_CLKBLK0:  next_cb_cfg[0] = pwdata[15:0];
        `PRC_OFF_CLKBLK1:  next_cb_cfg[1] = pwdata[15:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mul_f          <= `PRC_F_00;
      ref_r          <= `PRC_R_DEF;
      output_divider <= `PRC_OD_00;
      osc_mhz        <= `PRC_OSC_RST;
      port_sel       <= `PRC_PORT_SEL_RST;
      cb_cfg[0]      <= `PRC_CB_RST;
      cb_cfg[1]      <= `PRC_CB_RST;
    end else begin
      mul_f          <= next_mul_f;
      ref_r          <= next_ref_r;
      output_divider <= next_output_divider;
      osc_mhz        <= next_osc_mhz;
      port_sel       <= next_port_sel;
      cb_cfg         <= next_cb_cfg;
    end
  end
  // ratio arithmetic and intermediate-frequency window flag
  always_comb begin
    step     = 24'(osc_mhz) * (24'(mul_f) + 24'h1); // full-width product
    if_mod   = 24'(2 * (ref_r + 7'h1) * `PRC_CLK_MHZ);
    tile_mod = 24'(2 * (ref_r + 7'h1) * (output_divider + 4'h1) * `PRC_CLK_MHZ);
    lo_lim   = 24'(2 * `PRC_IF_MIN_MHZ * (ref_r + 7'h1));
    hi_lim   = 24'(2 * `PRC_IF_MAX_MHZ * (ref_r + 7'h1));
    range_err = (step < lo_lim) | (step > hi_lim);
  end
  // pll, tile and reference enables, all gated until settled
  prc_ratio_ce u_pll_ce (.pclk(pclk), .presetn(presetn), .enable(pll_locked),
                         .inc(step), .modulus(if_mod), .tick(pll_tick));
  prc_ratio_ce u_tile_ce (.pclk(pclk), .presetn(presetn), .enable(pll_locked),
                          .inc(step), .modulus(tile_mod), .tick(tile_tick));
  prc_ratio_ce u_ref_ce (.pclk(pclk), .presetn(presetn), .enable(pll_locked),
                         .inc(24'(`PRC_REF_MHZ)), .modulus(24'(`PRC_CLK_MHZ)),
                         .tick(ref_tick));
  assign switch_tick = tile_tick;
  // timers and clock blocks
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_blk
      logic [31:0] next_timer;
      logic [7:0]  div_cnt, next_div_cnt;
      logic        ext_prev, pin_lvl, next_pin_lvl, next_cb_tick;
      always_comb begin
        next_timer   = ref_tick ? timer[gi] + 32'h1 : timer[gi];
        next_div_cnt = div_cnt;
        next_cb_tick = 1'b0;
        if (cb_cfg[gi][`PRC_CB_SRC_EXT]) begin
          next_cb_tick = ext_clk_pin[gi] & ~ext_prev;
        end else if (ref_tick) begin
          if (div_cnt >= cb_cfg[gi][`PRC_CB_DIV_MSB:`PRC_CB_DIV_LSB]) begin
            next_div_cnt = '0;
            next_cb_tick = 1'b1;
          end else begin
            next_div_cnt = div_cnt + 8'h1;
          end
        end
        next_pin_lvl = pin_lvl ^ next_cb_tick;
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          timer[gi]   <= '0;
          div_cnt     <= '0;
          ext_prev    <= 1'b0;
          pin_lvl     <= 1'b0;
          cb_tick[gi] <= 1'b0;
        end else begin
          timer[gi]   <= next_timer;
          div_cnt     <= next_div_cnt;
          ext_prev    <= ext_clk_pin[gi];
          pin_lvl     <= next_pin_lvl;
          cb_tick[gi] <= next_cb_tick;
        end
      end
      assign clkblk_pin_out[gi] = pin_lvl;
      assign clkblk_pin_oe[gi]  = cb_cfg[gi][`PRC_CB_PIN_EN];
    end
    for (gi = 0; gi < 4; gi++) begin : g_port
      assign port_clk_tick[gi] = cb_tick[port_sel[gi]];
    end
  endgenerate
  // apb read data captured in the setup phase
  always_comb begin
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (rd_setup) begin
      case (paddr)
        `PRC_OFF_PLL_CFG:  next_prdata = {9'h0, output_divider, 2'h0, ref_r, mul_f};
        `PRC_OFF_STATUS:   next_prdata = {26'h0, strap, 1'b0, boot_done, range_err, pll_locked};
        `PRC_OFF_OSC_MHZ:  next_prdata = {24'h0, osc_mhz};
        `PRC_OFF_PORT_SEL: next_prdata = {28'h0, port_sel};
        `PRC_OFF_CLKBLK0:  next_prdata = {16'h0, cb_cfg[0]};
        `PRC_OFF_CLKBLK1:  next_prdata = {16'h0, cb_cfg[1]};
        `PRC_OFF_TIMER0:   next_prdata = timer[0];
        `PRC_OFF_TIMER1:   next_prdata = timer[1];
        default: begin
          next_prdata  = '0;
          next_pslverr = 1'b1;
        end
      endcase
    end else if (psel) begin
      next_pslverr = pslverr;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end
  // checks
  default clocking cb_chk @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_strap_third_edge: assert property ($rose(state == PRC_ST_SETTLE) && $past(state) == PRC_ST_STRAP |-> strap == $past({ratio_select_bit_high, ratio_select_bit_low})) else $error("strap not taken at third edge");
  a_strap_mul_00: assert property ($past(state) == PRC_ST_STRAP && state == PRC_ST_SETTLE && strap == 2'b00 |-> mul_f == 12'h07a && output_divider == 3'h1 && ref_r == 6'h0) else $error("bad default for strap 00");
  a_strap_mul_10: assert property ($past(state) == PRC_ST_STRAP && state == PRC_ST_SETTLE && strap == 2'b10 |-> mul_f == 12'h031 && output_divider == 3'h2) else $error("bad default for strap 10");
  a_gate_unlocked: assert property (!pll_locked |=> !tile_tick && !ref_tick) else $error("clock pulse while unlocked");
  a_settle_len: assert property ($rose(state == PRC_ST_SETTLE) |-> (state == PRC_ST_SETTLE)[*8]) else $error("settle ended early");
  a_cfg_relock: assert property (cfg_wr && state != PRC_ST_STRAP |=> state == PRC_ST_SETTLE && mul_f == $past(pwdata[11:0])) else $error("config write not applied");
  a_ref_rate: assert property (ref_tick |=> !ref_tick) else $error("reference faster than 100 MHz");
  a_ref_steady: assert property (pll_locked && $past(pll_locked, 3) |-> ref_tick || $past(ref_tick)) else $error("reference pulse missing");
  a_timer_step: assert property (ref_tick |=> timer[0] == $past(timer[0]) + 32'h1) else $error("timer did not advance");
  a_timer_hold: assert property (!ref_tick |=> timer[1] == $past(timer[1])) else $error("timer moved without tick");
  a_port_default: assert property ($rose(presetn) |-> port_sel == 4'h0 && !cb_cfg[0][0]) else $error("ports not on block 0");
  a_boot_after_lock: assert property ($rose(boot_done) |-> pll_locked && $past(pll_locked)) else $error("boot before lock");
  c_relock: cover property (cfg_wr ##1 state == PRC_ST_SETTLE ##[1:200] pll_locked);
  c_boot: cover property ($rose(boot_done));
  c_ext_clk: cover property (cb_cfg[1][0] && cb_tick[1]);
  c_range_err: cover property (pll_locked && range_err);
endmodule

`default_nettype wire

// ===== test/prc_board_model.sv
`timescale 1ns/1ps
`default_nettype none

// board straps and external clock sources at the far side of the block
module prc_board_model #(
  parameter int HALF = 10  // external clock half period in pclk cycles
) (
  input  wire logic       pclk,                   // system clock
  input  wire logic       presetn,                // reset, active low
  input  wire logic [1:0] strap_req,              // wanted pattern {high, low}
  input  wire logic [1:0] ext_run,                // external clock enable per pin
  output logic            ratio_select_bit_low,   // strap pin
  output logic            ratio_select_bit_high,  // strap pin
  output logic      [1:0] ext_clk_pin             // external clock pins
);
  int cnt;

  // straps move only while reset is held, so they stay put well past the third edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_select_bit_high <= strap_req[1];
      ratio_select_bit_low  <= strap_req[0];
    end
  end

  // free-running source; a pin that is not enabled stands low
  always @(posedge pclk) begin
    cnt         <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
    ext_clk_pin <= ext_run & {2{cnt < HALF}};
  end
endmodule

`default_nettype wire

// ===== test/tb_pll_ratio_clock_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "prc_defines.svh"

module tb_pll_ratio_clock_control;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sel_low;
  logic        sel_high;
  logic [1:0]  ext_clk_pin;
  logic [1:0]  strap_req;
  logic [1:0]  ext_run;
  logic        pll_tick;
  logic        switch_tick;
  logic        tile_tick;
  logic        ref_tick;
  logic [3:0]  port_clk_tick;
  logic [1:0]  clkblk_pin_out;
  logic [1:0]  clkblk_pin_oe;
  logic        pll_locked;
  logic        boot_done;
  int          failures;
  int          num_checks;
  logic [1:0]  pats [4] = '{2'b00, 2'b11, 2'b10, 2'b01};
  logic [31:0] cfgs [4] = '{32'h0010007a, 32'h00200077, 32'h00200031, 32'h00200017};

  prc_clock_control uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ratio_select_bit_low(sel_low), .ratio_select_bit_high(sel_high),
    .ext_clk_pin(ext_clk_pin), .pll_tick(pll_tick), .switch_tick(switch_tick),
    .tile_tick(tile_tick), .ref_tick(ref_tick), .port_clk_tick(port_clk_tick),
    .clkblk_pin_out(clkblk_pin_out), .clkblk_pin_oe(clkblk_pin_oe),
    .pll_locked(pll_locked), .boot_done(boot_done)
  );

  prc_board_model board (
    .pclk(pclk), .presetn(presetn), .strap_req(strap_req), .ext_run(ext_run),
    .ratio_select_bit_low(sel_low), .ratio_select_bit_high(sel_high),
    .ext_clk_pin(ext_clk_pin)
  );

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // verdict and end of run
  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // count compare with a tolerance for accumulator phase
  task automatic near(input int seen, input int exp, input int tol);
    check(32'(((seen >= exp - tol) && (seen <= exp + tol)) ? exp : seen), 32'(exp));
  endtask

  task automatic timeout;
    check(32'h0, 32'h1);
    test_done;
  endtask

  // one apb transfer, entered just after a rising edge, ends one idle edge later
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 50) timeout;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // tick counts over a window
  task automatic count(input int cyc, output int t, output int s, output int r,
                       output int p0, output int p1);
    t = 0; s = 0; r = 0; p0 = 0; p1 = 0;
    repeat (cyc) begin
      @(posedge pclk);
      t += tile_tick; s += switch_tick; r += ref_tick;
      p0 += port_clk_tick[0]; p1 += port_clk_tick[1];
    end
  endtask

  // reset with a strap pattern, then wait for lock
  task automatic do_reset(input logic [1:0] pat);
    int n;
    strap_req <= pat;
    presetn   <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    while (pll_locked !== 1'b1) begin
      @(posedge pclk);
      n++;
      if (n > 200) timeout;
    end
    near(n, 103, 2);
  endtask

  task automatic test_straps;
    logic [31:0] rd;
    logic        er;
    for (int i = 0; i < 4; i++) begin
      do_reset(pats[i]);
      apb(1'b0, `PRC_OFF_PLL_CFG, 32'h0, rd, er);
      check(rd & 32'h0073ffff, cfgs[i]);
      apb(1'b0, `PRC_OFF_STATUS, 32'h0, rd, er);
      check(rd & 32'h30, {26'h0, pats[i], 4'h0});
    end
    $display("test straps done");
  endtask

  task automatic test_boot;
    int n;
    do_reset(2'b01);
    check({31'h0, boot_done}, 32'h0);
    n = 0;
    while (boot_done !== 1'b1) begin
      @(posedge pclk);
      n++;
      if (n > 3100) timeout;
    end
    near(n, 3000, 3);
    $display("test boot done");
  endtask

  task automatic test_defaults;
    logic [31:0] rd;
    logic        er;
    int          t, s, r, p0, p1;
    apb(1'b0, `PRC_OFF_OSC_MHZ, 32'h0, rd, er);
    check(rd, 32'h00000019);
    apb(1'b0, `PRC_OFF_PORT_SEL, 32'h0, rd, er);
    check(rd, 32'h0);
    apb(1'b0, `PRC_OFF_CLKBLK0, 32'h0, rd, er);
    check(rd, 32'h0);
    count(200, t, s, r, p0, p1);
    near(t, 100, 1);
    check(32'(s), 32'(t));
    near(r, 100, 1);
    near(p0, 100, 1);
    $display("test defaults done");
  endtask

  task automatic test_reprogram;
    logic [31:0] rd;
    logic [31:0] t0;
    logic        er;
    int          n, t, s, r, p0, p1;
    apb(1'b1, `PRC_OFF_PLL_CFG, 32'h0070002f, rd, er);
    n = 0;
    t = 0;
    while (pll_locked !== 1'b1) begin
      @(posedge pclk);
      n++;
      t += (tile_tick !== 1'b0) + (ref_tick !== 1'b0); // unknown counts as a pulse
      if (n > 200) timeout;
    end
    check(32'(t), 32'h0);
    near(n, 100, 3);
    apb(1'b0, `PRC_OFF_PLL_CFG, 32'h0, rd, er);
    check(rd & 32'h0073ffff, 32'h0070002f);
    count(800, t, s, r, p0, p1);
    near(t, 300, 2);
    apb(1'b0, `PRC_OFF_TIMER0, 32'h0, t0, er);
    repeat (100) @(posedge pclk);
    apb(1'b0, `PRC_OFF_TIMER0, 32'h0, rd, er);
    near(int'(rd - t0), 52, 2);
    $display("test reprogram done");
  endtask

  task automatic test_blocks;
    logic [31:0] rd;
    logic        er;
    logic        lvl;
    int          t, s, r, p0, p1, n, k, m;
    apb(1'b1, `PRC_OFF_CLKBLK1, 32'h00000302, rd, er);
    apb(1'b1, `PRC_OFF_CLKBLK0, 32'h00000001, rd, er);
    apb(1'b1, `PRC_OFF_PORT_SEL, 32'h00000002, rd, er);
    ext_run <= 2'b01;
    count(400, t, s, r, p0, p1);
    near(p0, 20, 1);
    near(p1, 50, 1);
    check({30'h0, clkblk_pin_oe}, 32'h2);
    // pll rate saturates at 200 MHz, block 1 pin toggles per tick, port 3 on block 0
    n   = 0;
    k   = 0;
    m   = 0;
    lvl = clkblk_pin_out[1];
    repeat (80) begin
      @(posedge pclk);
      n  += (pll_tick === 1'b1);
      k  += (clkblk_pin_out[1] !== lvl);
      m  += (port_clk_tick[3] === 1'b1);
      lvl = clkblk_pin_out[1];
    end
    check(32'(n), 32'h50);
    near(k, 10, 1);
    near(m, 4, 1);
    $display("test blocks done");
  endtask

  task automatic test_errors;
    logic [31:0] rd;
    logic        er;
    apb(1'b1, `PRC_OFF_PLL_CFG, 32'h00000001, rd, er);
    apb(1'b0, `PRC_OFF_STATUS, 32'h0, rd, er);
    check(rd & 32'h2, 32'h2);
    apb(1'b0, 12'h020, 32'h0, rd, er);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    $display("test errors done");
  endtask

  // main sequence
  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    strap_req  = 2'b00;
    ext_run    = 2'b00;
    failures   = 0;
    num_checks = 0;
    @(posedge pclk);
    test_straps;
    test_boot;
    test_defaults;
    test_reprogram;
    test_blocks;
    test_errors;
    test_done;
  end
endmodule

`default_nettype wire
